/* asspi_dev.sv */
// Angle sensor end of the link: serial slave plus reply builder and timeout
`timescale 1ns/10ps
module asspi_dev #(
	parameter logic [5:0] NTT_OPCODE = 6'h30,
	parameter logic [5:0] ERR_OPCODE = 6'h3D,
	parameter int         ANGLE_BITS = 14
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	asspi_if.dev                  link,
	input  wire logic [ANGLE_BITS-1:0] alpha,
	input  wire logic [ANGLE_BITS-1:0] beta,
	input  wire logic [15:0]      field_x,
	input  wire logic [15:0]      field_y,
	input  wire logic [15:0]      field_z,
	input  wire logic [7:0]       gain,
	input  wire logic [1:0]       err_flags,
	output logic      [5:0]       roll_count,
	output logic                  bad_frame
);
	import asspi_pkg::*;

	localparam logic [PAYLOAD_BITS-1:0] NTT_PAYLOAD = {48'h0, MRK_CMD, NTT_OPCODE};
	localparam logic [PAYLOAD_BITS-1:0] ERR_PAYLOAD = {48'h0, MRK_CMD, ERR_OPCODE};

	// Link clock domain
	logic [6:0]            rx_cnt;
	logic [6:0]            tx_cnt;
	logic [FRAME_BITS-1:0] rx_shift;
	logic                  rx_done;
	logic                  miso_q;

	// Core clock domain
	logic [FRAME_BITS-1:0] reply;
	logic                  done_s;
	logic                  done_d;
	logic                  ss_s;
	logic                  ss_d;
	logic                  armed;
	logic [15:0]           tmo_left;
	logic [15:0]           us_cnt;

	// Bit counters restart whenever select is high, so partial frames leave no trace
	always_ff @(negedge link.sclk or posedge link.ss_n)
	begin
		if (link.ss_n)
			rx_cnt <= 7'h00;
		else
			rx_cnt <= rx_cnt + 7'h01;
	end

	// Mode 1: master data is sampled on the falling edge
	always_ff @(negedge link.sclk)
	begin
		rx_shift <= {rx_shift[FRAME_BITS-2:0], link.mosi};
	end

	// Held until the first falling edge of the next frame; only a full frame sets it
	always_ff @(negedge link.sclk or negedge rst_n)
	begin
		if (!rst_n)
			rx_done <= 1'b0;
		else
			rx_done <= (rx_cnt == 7'(FRAME_BITS - 1));
	end

	always_ff @(posedge link.sclk or posedge link.ss_n)
	begin
		if (link.ss_n)
			tx_cnt <= 7'h00;
		else
			tx_cnt <= tx_cnt + 7'h01;
	end

	// Reply bit index counts down from 63, giving byte 0 bit 7 first
	wire logic [5:0] tx_idx = ~tx_cnt[5:0];

	// Mode 1: slave data changes on the rising edge. The reply word is only
	// rewritten between frames, so it is quasi-static when read here.
	always_ff @(posedge link.sclk or negedge rst_n)
	begin
		if (!rst_n)
			miso_q <= 1'b0;
		else
			miso_q <= reply[tx_idx];
	end

	assign link.miso = miso_q;

	asspi_sync #(
		.INIT (1'b0)
	) u_done_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (rx_done),
		.q     (done_s)
	);

	asspi_sync #(
		.INIT (1'b1)
	) u_ss_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (link.ss_n),
		.q     (ss_s)
	);

	wire logic frame_evt = done_s & ~done_d;
	wire logic start_evt = ss_d & ~ss_s;

	// Decode of the received frame; rx_shift is stable until the next frame starts
	wire logic [7:0]  rb1    = asspi_byte(rx_shift, 1);
	wire logic [7:0]  rb2    = asspi_byte(rx_shift, 2);
	wire logic [7:0]  rb3    = asspi_byte(rx_shift, 3);
	wire logic [7:0]  rb6    = asspi_byte(rx_shift, 6);
	wire logic        crc_ok = asspi_crc(rx_shift[FRAME_BITS-1:8]) == rx_shift[7:0];
	wire logic [15:0] arg16  = {rb3, rb2};
	wire logic [1:0]  marker = rb6[7:6];
	wire logic        is_probe  = (rb6 == PROBE_REQ_B6);
	wire logic        is_single = (rb6[5:0] == SINGLE_OPC) && (marker != MRK_CMD);
	wire logic        clr_roll  = rb1[CLR_BIT];
	wire logic [5:0]  next_roll = clr_roll ? 6'h00 : roll_count + 6'h01;

	// Key echo: any value is accepted and returned as is, then its complement
	wire logic [PAYLOAD_BITS-1:0] echo_payload =
		{8'h00, 8'h00, arg16[7:0], arg16[15:8], ~arg16[7:0], ~arg16[15:8],
		 PROBE_RSP_B6};

	// The full 14-bit code maps one whole turn; joystick clamping is upstream
	wire logic [ANGLE_BITS-1:0] a = alpha;
	wire logic [ANGLE_BITS-1:0] b = beta;

	wire logic [PAYLOAD_BITS-1:0] single_payload =
		{a[7:0], err_flags, a[13:8], 8'h00, 8'h00, gain, 8'h00,
		 MRK_SINGLE, next_roll};

	wire logic [PAYLOAD_BITS-1:0] two_payload =
		{a[7:0], err_flags, a[13:8], b[7:0], 2'b00, b[13:8], gain, 8'h00,
		 MRK_TWO, next_roll};

	wire logic [PAYLOAD_BITS-1:0] xyz_payload =
		{field_x[7:0], field_x[15:8], field_y[7:0], field_y[15:8],
		 field_z[7:0], field_z[15:8], MRK_XYZ, next_roll};

	wire logic [PAYLOAD_BITS-1:0] data_payload =
		(marker == MRK_TWO) ? two_payload :
		(marker == MRK_XYZ) ? xyz_payload : single_payload;

	wire logic [PAYLOAD_BITS-1:0] next_payload =
		!crc_ok   ? ERR_PAYLOAD :
		is_probe  ? echo_payload :
		is_single ? data_payload : ERR_PAYLOAD;

	wire logic us_tick = (us_cnt == 16'(US_CYCLES - 1));
	// Expiry is only acted on with select high, so a reply never changes mid-frame
	wire logic expire  = armed & us_tick & (tmo_left == 16'h0000) & ss_s;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			done_d <= 1'b0;
			ss_d   <= 1'b1;
		end
		else
		begin
			done_d <= done_s;
			ss_d   <= ss_s;
		end
	end

	// The reply built here is shifted out during the following frame
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			reply <= asspi_seal(NTT_PAYLOAD);
		else if (frame_evt)
			reply <= asspi_seal(next_payload);
		else if (expire)
			reply <= asspi_seal(NTT_PAYLOAD);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			roll_count <= 6'h00;
		else if (frame_evt && crc_ok && is_single)
			roll_count <= next_roll;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			bad_frame <= 1'b0;
		else
			bad_frame <= frame_evt & ~crc_ok;
	end

	// Microsecond prescaler free-runs; restarted when a new timeout is armed
	always_ff @(posedge clk)
	begin
		if (!rst_n || (frame_evt && is_single) || us_tick)
			us_cnt <= 16'h0000;
		else
			us_cnt <= us_cnt + 16'h0001;
	end

	// Timeout runs from the request frame until the next frame starts
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			armed    <= 1'b0;
			tmo_left <= 16'h0000;
		end
		else if (frame_evt)
		begin
			armed    <= crc_ok & is_single;
			tmo_left <= arg16;
		end
		else if (start_evt || expire)
			armed <= 1'b0;
		else if (armed && us_tick && tmo_left != 16'h0000)
			tmo_left <= tmo_left - 16'h0001;
	end

endmodule // asspi_dev

/* asspi_pkg.sv */
// Shared constants, types and check-byte functions for the angle sensor link
// Function
// - Link uses SPI clock mode 1 only
// - Frame order is byte 0 first, byte 7 last
// - Each byte shifts most significant bit first
// - Master keeps clock within glitch filter limit
// - Probe request carries key and 0xD0 pattern
// - Probe reply echoes key, inverted key, 0xD1
// - Any key echoed unchanged, inverse is complement
// - Reply in each frame answers previous command
// - Single-angle request layout: clear bit, timeout, marker
// - Counter-clear bit resets the rolling counter
// - Late retrieval gets nothing-to-transmit reply
// - Timeout counts one microsecond per step
// - Payload is one angle, two angles, or xyz
// - Angle uses fourteen bits over full turn
// - Angle span covers the full 360 degrees
// - Master checks check byte of each reply it returns
// - Angle in byte 0 and byte 1 low bits
// - Gain in byte 4, rolling counter in byte 6
// - Master interlaces probes after each angle request
// - Byte 6 top bits select the message type
// - Byte 6 low bits: rolling counter or opcode
// - Check byte over bytes 0-6, init 0xFF, inverted
package asspi_pkg;

	localparam int FRAME_BITS   = 64;
	localparam int PAYLOAD_BITS = 56;

	localparam int CLK_PERIOD_NS   = 8;
	localparam int CLK_HZ          = 125_000_000;
	localparam int TIMEOUT_LSB_NS  = 1000;
	localparam int US_CYCLES       = (TIMEOUT_LSB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LINK_START_HZ   = 500_000;
	localparam int LINK_HALF_CYCLES = CLK_HZ / (2 * LINK_START_HZ);
	localparam int FRAME_GAP_CYCLES = LINK_HALF_CYCLES;

	localparam logic [7:0] PROBE_REQ_B6 = 8'hD0;
	localparam logic [7:0] PROBE_RSP_B6 = 8'hD1;
	localparam logic [5:0] SINGLE_OPC   = 6'h13;
	localparam logic [1:0] MRK_SINGLE   = 2'h0;
	localparam logic [1:0] MRK_TWO      = 2'h1;
	localparam logic [1:0] MRK_XYZ      = 2'h2;
	localparam logic [1:0] MRK_CMD      = 2'h3;
	localparam logic [7:0] CRC_POLY     = 8'h2F;
	localparam logic [7:0] CRC_INIT     = 8'hFF;
	localparam int         CLR_BIT      = 0;

	typedef enum logic {ASSPI_CMD_PROBE, ASSPI_CMD_SINGLE} asspi_cmd_t;

	// Bitwise form of the byte lookup: feeding bits MSB first is the same CRC
	function automatic logic [7:0] asspi_crc(input logic [PAYLOAD_BITS-1:0] d);
		logic [7:0] c;
		logic       fb;
		c  = CRC_INIT;
		fb = 1'b0;
		for (int i = PAYLOAD_BITS - 1; i >= 0; i--)
		begin
			fb = c[7] ^ d[i];
			c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
		end
		return ~c;
	endfunction

	// Byte 0 sits in the top bits so the frame shifts out in byte order
	function automatic logic [FRAME_BITS-1:0] asspi_seal(input logic [PAYLOAD_BITS-1:0] p);
		return {p, asspi_crc(p)};
	endfunction

	function automatic logic [7:0] asspi_byte(input logic [FRAME_BITS-1:0] f, input int n);
		return f[FRAME_BITS - 1 - 8 * n -: 8];
	endfunction

endpackage

/* asspi_if.sv */
// Four-wire serial link between the angle sensor and its master
`timescale 1ns/10ps
interface asspi_if;
	logic sclk;
	logic ss_n;
	logic mosi;
	logic miso;

	modport dev
	(
		input  sclk,
		input  ss_n,
		input  mosi,
		output miso
	);

	modport host
	(
		output sclk,
		output ss_n,
		output mosi,
		input  miso
	);
endinterface

/* asspi_sync.sv */
// Three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/10ps
module asspi_sync #(
	parameter logic INIT = 1'b0
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic d,
	output logic      q
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
			q  <= INIT;
		end
		else
		begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				q <= s3;
		end
	end
endmodule // asspi_sync

/* asspi_host.sv */
// Master end of the link: builds requests, makes the link clock, checks replies
`timescale 1ns/10ps
module asspi_host #(
	parameter int          HALF_CYCLES = asspi_pkg::LINK_HALF_CYCLES,
	parameter int          GAP_CYCLES  = asspi_pkg::FRAME_GAP_CYCLES,
	parameter logic [15:0] COLLECT_KEY = 16'hAAAA
) (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	asspi_if.host                       link,
	input  wire logic                   req_valid,
	input  wire asspi_pkg::asspi_cmd_t  req_kind,
	input  wire logic [15:0]            req_arg,
	input  wire logic                   req_clr,
	input  wire logic [1:0]             req_marker,
	output logic                        req_ready,
	output logic                        resp_valid,
	output logic [63:0]                 resp_word,
	output logic                        resp_crc_ok
);
	import asspi_pkg::*;

	typedef enum logic [2:0] {H_IDLE, H_LEAD, H_SHIFT, H_TRAIL, H_GAP} asspi_hstate_t;

	asspi_hstate_t         state;
	logic [15:0]           hc;
	logic [5:0]            bitn;
	logic [FRAME_BITS-1:0] tx;
	logic [FRAME_BITS-1:0] rx;
	logic                  follow;
	logic                  sclk_q;
	logic                  ss_q;
	logic                  mosi_q;
	logic                  miso_s;

	asspi_sync #(
		.INIT (1'b0)
	) u_miso_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (link.miso),
		.q     (miso_s)
	);

	wire logic [PAYLOAD_BITS-1:0] probe_payload =
		{8'h00, 8'h00, req_arg[7:0], req_arg[15:8], 8'h00, 8'h00, PROBE_REQ_B6};
	wire logic [PAYLOAD_BITS-1:0] collect_payload =
		{8'h00, 8'h00, COLLECT_KEY[7:0], COLLECT_KEY[15:8], 8'h00, 8'h00,
		 PROBE_REQ_B6};
	wire logic [PAYLOAD_BITS-1:0] single_payload =
		{8'h00, 7'h00, req_clr, req_arg[7:0], req_arg[15:8], 8'h00, 8'h00,
		 req_marker, SINGLE_OPC};
	wire logic [PAYLOAD_BITS-1:0] req_payload =
		(req_kind == ASSPI_CMD_SINGLE) ? single_payload : probe_payload;

	wire logic            hc_done   = (hc == 16'h0000);
	wire logic [15:0]     half_load = 16'(HALF_CYCLES - 1);
	wire logic [15:0]     gap_load  = 16'(GAP_CYCLES - 1);
	wire logic            rx_crc_ok = asspi_crc(rx[FRAME_BITS-1:8]) == rx[7:0];

	assign link.sclk = sclk_q;
	assign link.ss_n = ss_q;
	assign link.mosi = mosi_q;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state       <= H_IDLE;
			hc          <= 16'h0000;
			bitn        <= 6'h00;
			tx          <= 64'h0;
			rx          <= 64'h0;
			follow      <= 1'b0;
			sclk_q      <= 1'b0;
			ss_q        <= 1'b1;
			mosi_q      <= 1'b0;
			req_ready   <= 1'b0;
			resp_valid  <= 1'b0;
			resp_word   <= 64'h0;
			resp_crc_ok <= 1'b0;
		end
		else
		begin
			resp_valid <= 1'b0;
			if (!hc_done)
				hc <= hc - 16'h0001;
			unique case (state)
				H_IDLE:
				begin
					req_ready <= 1'b1;
					if (req_valid && req_ready)
					begin
						req_ready <= 1'b0;
						tx        <= asspi_seal(req_payload);
						follow    <= (req_kind == ASSPI_CMD_SINGLE);
						ss_q      <= 1'b0;
						hc        <= half_load;
						state     <= H_LEAD;
					end
				end
				H_LEAD:
				begin
					if (hc_done)
					begin
						sclk_q <= 1'b1;
						mosi_q <= tx[FRAME_BITS-1];
						bitn   <= 6'h00;
						hc     <= half_load;
						state  <= H_SHIFT;
					end
				end
				H_SHIFT:
				begin
					if (hc_done)
					begin
						hc <= half_load;
						// Mode 1: clock idles low, drive on rise, sample on fall
						if (sclk_q)
						begin
							sclk_q <= 1'b0;
							rx     <= {rx[FRAME_BITS-2:0], miso_s};
							if (bitn == 6'h3F)
								state <= H_TRAIL;
							else
								bitn <= bitn + 6'h01;
						end
						else
						begin
							sclk_q <= 1'b1;
							mosi_q <= tx[~bitn];
						end
					end
				end
				H_TRAIL:
				begin
					if (hc_done)
					begin
						ss_q  <= 1'b1;
						hc    <= gap_load;
						state <= H_GAP;
					end
				end
				H_GAP:
				begin
					if (hc_done)
					begin
						// An angle request is always chased by a probe to collect its data
						if (follow)
						begin
							follow <= 1'b0;
							tx     <= asspi_seal(collect_payload);
							ss_q   <= 1'b0;
							hc     <= half_load;
							state  <= H_LEAD;
						end
						else
						begin
							resp_valid  <= 1'b1;
							resp_word   <= rx;
							resp_crc_ok <= rx_crc_ok;
							state       <= H_IDLE;
						end
					end
				end
			endcase
		end
	end
endmodule // asspi_host

/* asspi_props.sv */
// Link timing checker for the angle sensor serial link
`timescale 1ns/10ps
module asspi_props #(
	parameter int HALF = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic miso
);
	logic       sclk_q;
	logic [6:0] rises;
	int         low_cyc;

	// Counts stay valid at the closing select edge, cleared only once deselect is seen
	always_ff @(posedge clk)
	begin
		sclk_q <= sclk;
		if (!rst_n || ss_n)
		begin
			rises   <= 7'h00;
			low_cyc <= 0;
		end
		else
		begin
			rises   <= rises + ((sclk && !sclk_q) ? 7'h01 : 7'h00);
			low_cyc <= low_cyc + 1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_idle_clk_low: assert property (ss_n |-> !sclk)
		else $error("link clock active while deselected");
	chk_mosi_on_rise: assert property ($changed(mosi) && !ss_n |-> $rose(sclk))
		else $error("master data moved away from a rising clock");
	chk_miso_in_high: assert property ($changed(miso) && !ss_n |-> sclk)
		else $error("sensor data moved while clock low");
	chk_clk_half_high: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
		else $error("link clock high phase has wrong length");
	chk_select_setup: assert property ($fell(ss_n) |-> !sclk[*6])
		else $error("clock edge too soon after select");
	chk_frame_bits: assert property ($rose(ss_n) |-> rises == 7'd64)
		else $error("frame did not carry 64 clocks");
	chk_frame_time: assert property ($rose(ss_n) |-> low_cyc >= 128 * HALF && low_cyc <= 131 * HALF)
		else $error("select low period has wrong length");
	chk_gap_high: assert property ($rose(ss_n) |-> ss_n[*8])
		else $error("select gap between frames too short");
endmodule // asspi_props

/* test_angle_sensor_spi_messaging.sv */
// Bench joining both link ends, with a slow second pair for late collection
`timescale 1ns/10ps
module test_angle_sensor_spi_messaging;
	import asspi_pkg::*;
	localparam logic [5:0] NOTHING_TO_TRANSMIT_REPLY = 6'h30;
	localparam logic [5:0] ERR = 6'h3D;
	logic        clk;
	logic        rst_n;
	logic [1:0]  req_valid;
	asspi_cmd_t  req_kind;
	logic [15:0] req_arg;
	logic        req_clr;
	logic [1:0]  req_marker;
	logic [1:0]  req_ready;
	logic [1:0]  resp_valid;
	logic [63:0] resp_word [2];
	logic [1:0]  crc_ok;
	logic [13:0] alpha;
	logic [13:0] beta;
	logic [15:0] fx;
	logic [15:0] fy;
	logic [15:0] fz;
	logic [7:0]  gain;
	logic [1:0]  err;
	logic [5:0]  roll [2];
	logic [63:0] got;
	logic [15:0] prev;
	logic [15:0] keys [3];
	logic [1:0]  mk;
	logic [1:0]  bad;
	int          n_bad = 0;
	int          errors;
	int          n_tests;

	asspi_if lnk0();
	asspi_if lnk1();

	asspi_dev #(.NTT_OPCODE(NOTHING_TO_TRANSMIT_REPLY), .ERR_OPCODE(ERR)) i_asspi_dev (.clk(clk), .rst_n(rst_n),
		.link(lnk0), .alpha(alpha), .beta(beta), .field_x(fx), .field_y(fy), .field_z(fz),
		.gain(gain), .err_flags(err), .roll_count(roll[0]), .bad_frame(bad[0]));
	asspi_dev #(.NTT_OPCODE(NOTHING_TO_TRANSMIT_REPLY), .ERR_OPCODE(ERR)) i_asspi_dev_b (.clk(clk), .rst_n(rst_n),
		.link(lnk1), .alpha(alpha), .beta(beta), .field_x(fx), .field_y(fy), .field_z(fz),
		.gain(gain), .err_flags(err), .roll_count(roll[1]), .bad_frame(bad[1]));

	// Both masters always seal correctly, so any bad-frame pulse is a fault
	always @(posedge clk)
	begin
		if (rst_n && bad != 2'b00)
			n_bad <= n_bad + 1;
	end
	asspi_host #(.HALF_CYCLES(8), .GAP_CYCLES(10)) i_asspi_host (.clk(clk), .rst_n(rst_n),
		.link(lnk0), .req_valid(req_valid[0]), .req_kind(req_kind), .req_arg(req_arg),
		.req_clr(req_clr), .req_marker(req_marker), .req_ready(req_ready[0]),
		.resp_valid(resp_valid[0]), .resp_word(resp_word[0]), .resp_crc_ok(crc_ok[0]));
	// Long gap pushes the collecting frame past a short timeout
	asspi_host #(.HALF_CYCLES(8), .GAP_CYCLES(200)) i_asspi_host_b (.clk(clk), .rst_n(rst_n),
		.link(lnk1), .req_valid(req_valid[1]), .req_kind(req_kind), .req_arg(req_arg),
		.req_clr(req_clr), .req_marker(req_marker), .req_ready(req_ready[1]),
		.resp_valid(resp_valid[1]), .resp_word(resp_word[1]), .resp_crc_ok(crc_ok[1]));
	asspi_props #(.HALF(8)) i_asspi_props (.clk(clk), .rst_n(rst_n), .sclk(lnk0.sclk),
		.ss_n(lnk0.ss_n), .mosi(lnk0.mosi), .miso(lnk0.miso));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	function automatic logic [63:0] seal(input logic [55:0] p);
		logic [7:0] c;
		c = 8'hFF;
		for (int i = 6; i >= 0; i--)
		begin
			c = c ^ p[8*i +: 8];
			for (int b = 0; b < 8; b++)
				c = c[7] ? ({c[6:0], 1'b0} ^ 8'h2F) : {c[6:0], 1'b0};
		end
		return {p, ~c};
	endfunction

	function automatic logic [55:0] meas(input logic [1:0] m, input logic [5:0] n);
		if (m == 2'h2)
			return {fx[7:0], fx[15:8], fy[7:0], fy[15:8], fz[7:0], fz[15:8], m, n};
		return {alpha[7:0], err, alpha[13:8],
			(m == 2'h1) ? {beta[7:0], 2'b00, beta[13:8]} : 16'h0000, gain, 8'h00, m, n};
	endfunction

	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic xfer(input int s, input asspi_cmd_t k, input logic [15:0] a,
		input logic c, input logic [1:0] m);
		int n;
		n = 0;
		req_kind <= k;
		req_arg <= a;
		req_clr <= c;
		req_marker <= m;
		req_valid[s] <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (req_ready[s] !== 1'b1 && n < 5000);
		req_valid[s] <= 1'b0;
		while (resp_valid[s] !== 1'b1 && n < 5000)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 5000)
		begin
			errors++;
			$display("unexpected at %0t: no reply", $time);
			conclude();
		end
		got = resp_word[s];
		check({63'h0, crc_ok[s]}, 64'h1);
	endtask

	initial
	begin
		errors = 0;
		n_tests = 0;
		rst_n = 1'b0;
		req_valid = 2'b00;
		req_kind = ASSPI_CMD_PROBE;
		req_arg = 16'h0000;
		req_clr = 1'b0;
		req_marker = 2'h0;
		alpha = 14'h2ABC;
		beta = 14'h1357;
		fx = 16'h1122;
		fy = 16'h3344;
		fz = 16'h5566;
		gain = 8'h9A;
		err = 2'b10;
		keys = '{16'h0000, 16'hFFFF, 16'hA5C3};
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		// Nothing was asked yet, so the idle reply comes back
		xfer(0, ASSPI_CMD_PROBE, 16'h1234, 1'b0, 2'h0);
		check(got, seal({48'h0, 2'h3, NOTHING_TO_TRANSMIT_REPLY}));
		prev = 16'h1234;
		foreach (keys[i])
		begin
			xfer(0, ASSPI_CMD_PROBE, keys[i], 1'b0, 2'h0);
			check(got, seal({16'h0, prev[7:0], prev[15:8], ~prev[7:0], ~prev[15:8], 8'hD1}));
			prev = keys[i];
		end
		for (int i = 0; i < 4; i++)
		begin
			alpha <= alpha + 14'h1555;
			gain <= gain + 8'h11;
			err <= err + 2'b01;
			mk = (i == 0) ? 2'h0 : 2'(i - 1);
			xfer(0, ASSPI_CMD_SINGLE, 16'hFFFF, i == 0, mk);
			check(got, seal(meas(mk, 6'(i))));
			check({58'h0, roll[0]}, 64'(i));
		end
		// Command marker on an angle request is not a measurement: error reply, counter kept
		xfer(0, ASSPI_CMD_SINGLE, 16'h0000, 1'b0, 2'h3);
		check(got, seal({48'h0, 2'h3, ERR}));
		check({58'h0, roll[0]}, 64'h3);
		// Timeout of 0 runs out during the long gap, 1 does not
		xfer(1, ASSPI_CMD_SINGLE, 16'h0000, 1'b1, 2'h0);
		check(got, seal({48'h0, 2'h3, NOTHING_TO_TRANSMIT_REPLY}));
		xfer(1, ASSPI_CMD_SINGLE, 16'h0001, 1'b1, 2'h0);
		check(got, seal(meas(2'h0, 6'h00)));
		check({58'h0, roll[1]}, 64'h0);
		check(64'(n_bad), 64'h0);
		conclude();
	end
endmodule // test_angle_sensor_spi_messaging
